// *** rtl/apc_capture.sv ***
/*
 * axis position capture latch: one hardware latch armed from a single
 * argument, three logical latches with 4-bit source selectors, zero mark
 * source, interpolated capture, and static origin loading.
 * assumes pins are asynchronous and encoder samples are on this clock.
 */
`timescale 1ns/10ps
module apc_capture (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	// physical registration pins and zero mark
	input  wire logic [2:0]                    reg_pin,
	input  wire logic                          zero_mark_pin,
	// encoder sample stream
	input  wire logic                          enc_sample_valid,
	input  wire logic [apc_pkg::POS_W-1:0]      enc_sample,
	input  wire logic [apc_pkg::POS_W-1:0]      abs_enc_position,
	input  wire logic                          abs_encoder_fitted,
	// selector configuration for latch a, b, c
	input  wire logic [11:0]                   latch_source_selector,
	// arming command
	input  wire logic                          arm_position_capture,
	input  wire apc_pkg::apc_arg_t             arm_arg,
	// origin commands
	input  wire logic                          origin_search_command,
	input  wire logic                          origin_load,
	input  wire logic                          origin_load_abs,
	input  wire logic [apc_pkg::POS_W-1:0]      origin_value,
	input  wire logic [apc_pkg::POS_W-1:0]      demanded_in,
	// status outputs
	output logic                               capture_armed,
	output logic                               capture_done,
	output logic [apc_pkg::POS_W-1:0]           captured_position,
	output logic [apc_pkg::POS_W-1:0]           measured_position,
	output logic [apc_pkg::POS_W-1:0]           demanded_position,
	output logic                               axis_error,
	output logic                               origin_refused
);

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_INTERP} apc_state_t;

	// reset release
	logic [1:0] rst_pipe_reg;
	logic       rst_sync_n;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_reg[1];

	// pin synchronisers: three stages, level taken when stages two and three agree
	logic [3:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
	logic [3:0] pin_next;
	always_comb begin
		pin_next = pin_reg;
		for (int i = 0; i < 4; i++) begin
			if (sync2_reg[i] == sync3_reg[i]) begin
				pin_next[i] = sync3_reg[i];
			end
		end
	end
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
			pin_reg   <= 4'h0;
		end else begin
			sync1_reg <= {zero_mark_pin, reg_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg   <= pin_next;
		end
	end

	// selector decode: level of a logical latch, and whether it can trigger
	function automatic logic [1:0] sel_decode(input logic [3:0] sel, input logic [2:0] pins);
		logic [1:0] r;
		r = 2'h0;
		case (sel)
			apc_pkg::SEL_RISE_IN0:  r = {1'b1, pins[0]};
			apc_pkg::SEL_RISE_IN1:  r = {1'b1, pins[1]};
			apc_pkg::SEL_RISE_IN2:  r = {1'b1, pins[2]};
			apc_pkg::SEL_FORCE_OFF: r = 2'h0;
			apc_pkg::SEL_FORCE_ON:  r = 2'h1;
			apc_pkg::SEL_FALL_IN0:  r = {1'b1, ~pins[0]};
			apc_pkg::SEL_FALL_IN1:  r = {1'b1, ~pins[1]};
			apc_pkg::SEL_FALL_IN2:  r = {1'b1, ~pins[2]};
			default:                r = 2'h0; // unused codes never trigger
		endcase
		return r;
	endfunction : sel_decode

	// single latch, one source at a time
	logic [1:0] dec_a, dec_b, dec_c;
	logic       src_level, src_live;
	apc_pkg::apc_arg_t arg_reg, arg_next;
	always_comb begin
		dec_a = sel_decode(latch_source_selector[3:0], pin_reg[2:0]);
		dec_b = sel_decode(latch_source_selector[7:4], pin_reg[2:0]);
		dec_c = sel_decode(latch_source_selector[11:8], pin_reg[2:0]);
		case (arg_reg.source)
			apc_pkg::SRC_LATCH_A: {src_live, src_level} = dec_a;
			apc_pkg::SRC_LATCH_B: {src_live, src_level} = dec_b;
			apc_pkg::SRC_LATCH_C: {src_live, src_level} = dec_c;
			apc_pkg::SRC_ZERO:    {src_live, src_level} = {1'b1, pin_reg[3]};
			default:              {src_live, src_level} = 2'h0;
		endcase
		src_level = src_level ^ arg_reg.invert_edge;
	end

	// encoder history kept beside the latch
	logic [apc_pkg::POS_W-1:0]   prev_reg, last_reg, prev_next, last_next;
	logic [apc_pkg::PHASE_W-1:0] phase_reg, phase_next;
	always_comb begin
		prev_next  = prev_reg;
		last_next  = last_reg;
		phase_next = phase_reg + 1'b1;
		if (enc_sample_valid) begin
			prev_next  = last_reg;
			last_next  = enc_sample;
			phase_next = '0;
		end
	end

	apc_state_t state_reg, state_next;
	logic       armed_reg, armed_next;
	logic       level_reg, level_next;
	logic       done_reg, done_next;
	logic       start_interp;
	logic       interp_done;
	logic [apc_pkg::POS_W-1:0] interp_pos;
	logic [apc_pkg::POS_W-1:0] cap_reg, cap_next;
	always_comb begin
		state_next   = state_reg;
		arg_next     = arg_reg;
		done_next    = done_reg;
		cap_next     = cap_reg;
		level_next   = src_level;
		start_interp = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// re-arm only by a new command
				if (arm_position_capture) begin
					arg_next   = arm_arg;
					done_next  = 1'b0;
					level_next = 1'b1; // no edge on the arming cycle
					state_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (src_live && src_level && !level_reg) begin
					start_interp = 1'b1;
					state_next   = ST_INTERP;
				end
			end
			ST_INTERP: begin
				// result stored within a few cycles
				if (interp_done) begin
					cap_next   = interp_pos;
					done_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		armed_next = (state_next != ST_IDLE); // registered so the output is a flop
	end

	apc_interp u_interp (
		.clock      (clock),
		.rst_sync_n (rst_sync_n),
		.start      (start_interp),
		.pos_prev   (prev_reg),
		.pos_last   (last_reg),
		.phase      (phase_reg),
		.done       (interp_done),
		.pos_out    (interp_pos)
	);

	// origin operations on measured and demanded position
	// offset keeps a loaded origin while the encoder moves on
	logic [apc_pkg::POS_W-1:0] meas_reg, meas_next, dem_reg, dem_next;
	logic [apc_pkg::POS_W-1:0] off_reg, off_next;
	logic                     err_reg, err_next, refused_reg, refused_next;
	always_comb begin
		off_next     = off_reg;
		dem_next     = demanded_in;
		err_next     = err_reg;
		refused_next = 1'b0;
		if (origin_load) begin
			off_next = origin_value - last_next;
		end else if (origin_load_abs) begin
			if (abs_encoder_fitted) begin
				off_next = abs_enc_position - last_next;
			end else begin
				refused_next = 1'b1;
			end
		end
		meas_next = last_next + off_next;
		if (origin_search_command) begin
			dem_next = meas_reg;
			err_next = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg   <= ST_IDLE;
			arg_reg     <= '0;
			level_reg   <= 1'b1;
			done_reg    <= 1'b0;
			cap_reg     <= '0;
			prev_reg    <= '0;
			last_reg    <= '0;
			phase_reg   <= '0;
			meas_reg    <= '0;
			off_reg     <= '0;
			armed_reg   <= 1'b0;
			dem_reg     <= '0;
			err_reg     <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			arg_reg     <= arg_next;
			level_reg   <= level_next;
			done_reg    <= done_next;
			cap_reg     <= cap_next;
			prev_reg    <= prev_next;
			last_reg    <= last_next;
			phase_reg   <= phase_next;
			meas_reg    <= meas_next;
			off_reg     <= off_next;
			armed_reg   <= armed_next;
			dem_reg     <= dem_next;
			err_reg     <= err_next;
			refused_reg <= refused_next;
		end
	end

	assign capture_armed     = armed_reg;
	assign capture_done      = done_reg;
	assign captured_position = cap_reg;
	assign measured_position = meas_reg;
	assign demanded_position = dem_reg;
	assign axis_error        = err_reg;
	assign origin_refused    = refused_reg;

endmodule : apc_capture

// *** rtl/apc_interp.sv ***
/*
 * interpolator: position at an edge between two sampled encoder values.
 * assumes samples arrive at a steady 62.5 us spacing on the local clock.
 */
`timescale 1ns/10ps
module apc_interp (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst_sync_n,
	// edge capture request
	input  wire logic                      start,
	input  wire logic [apc_pkg::POS_W-1:0]  pos_prev,
	input  wire logic [apc_pkg::POS_W-1:0]  pos_last,
	input  wire logic [apc_pkg::PHASE_W-1:0] phase,
	// interpolated result, one cycle after start
	output logic                           done,
	output logic [apc_pkg::POS_W-1:0]       pos_out
);

	logic                     done_reg;
	logic                     done_next;
	logic [apc_pkg::POS_W-1:0] pos_reg;
	logic [apc_pkg::POS_W-1:0] pos_next;
	logic signed [apc_pkg::POS_W+apc_pkg::PHASE_W:0] prod;

	// linear extrapolation of the last step by elapsed phase
	always_comb begin
		prod      = $signed(pos_last - pos_prev) * $signed({1'b0, phase});
		pos_next  = pos_reg;
		done_next = start;
		if (start) begin
			pos_next = pos_last + apc_pkg::POS_W'(prod / apc_pkg::SAMPLE_CYC);
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			done_reg <= 1'b0;
			pos_reg  <= '0;
		end else begin
			done_reg <= done_next;
			pos_reg  <= pos_next;
		end
	end

	assign done    = done_reg;
	assign pos_out = pos_reg;

endmodule : apc_interp

// *** rtl/apc_pkg.sv ***
/*
 * package for the axis position capture latch: selector codes, source codes,
 * timing constants and the carrier structs shared by the design files.
 * assumes a single 100 MHz clock domain.
 */
package apc_pkg;

	localparam int POS_W = 32;

	// latch source selector codes, one 4-bit field per logical latch
	localparam logic [3:0] SEL_RISE_IN0  = 4'h4;
	localparam logic [3:0] SEL_RISE_IN1  = 4'h5;
	localparam logic [3:0] SEL_RISE_IN2  = 4'h6;
	localparam logic [3:0] SEL_FORCE_OFF = 4'h7;
	localparam logic [3:0] SEL_FORCE_ON  = 4'h8;
	localparam logic [3:0] SEL_FALL_IN0  = 4'hD;
	localparam logic [3:0] SEL_FALL_IN1  = 4'hE;
	localparam logic [3:0] SEL_FALL_IN2  = 4'hF;

	// capture argument source field: which logical latch or the zero mark
	localparam logic [1:0] SRC_LATCH_A = 2'h0;
	localparam logic [1:0] SRC_LATCH_B = 2'h1;
	localparam logic [1:0] SRC_LATCH_C = 2'h2;
	localparam logic [1:0] SRC_ZERO    = 2'h3;

	// timing
	localparam int CLK_MHZ         = 100;
	localparam int CAPTURE_MAX_NS  = 3000;
	localparam int CAPTURE_MAX_CYC = (CAPTURE_MAX_NS * CLK_MHZ) / 1000;
	localparam int SAMPLE_NS       = 62500;
	localparam int SAMPLE_CYC      = (SAMPLE_NS * CLK_MHZ) / 1000;
	localparam int PHASE_W         = 13;

	// reset values
	localparam logic [11:0] SEL_RESET = {SEL_FORCE_OFF, SEL_FORCE_OFF, SEL_FORCE_OFF};

	// capture argument as given with the arm command
	typedef struct packed {
		logic [1:0] source;        // logical latch or zero mark
		logic       invert_edge;   // swap rising/falling of the chosen signal
		logic       window_en;     // windowing requested
	} apc_arg_t;

	// result of a capture
	typedef struct packed {
		logic             valid;
		logic [POS_W-1:0] position;
	} apc_result_t;

endpackage : apc_pkg

// *** sim/apc_capture_checker.sv ***
/* assertions on apc_capture ports: arming, capture, origin loads.
   assumes the top clock and rst_n; bound at the foot. */
`timescale 1ns/10ps
module apc_capture_checker (
	// clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// capture
	input wire logic [2:0]        reg_pin,
	input wire logic [11:0]       latch_source_selector,
	input wire logic              arm_position_capture,
	input wire apc_pkg::apc_arg_t arm_arg,
	input wire logic              capture_armed,
	input wire logic              capture_done,
	input wire logic [31:0]       captured_position,
	// origin
	input wire logic              origin_search_command,
	input wire logic              origin_load,
	input wire logic              origin_load_abs,
	input wire logic              abs_encoder_fitted,
	input wire logic [31:0]       origin_value,
	input wire logic [31:0]       measured_position,
	input wire logic [31:0]       demanded_position,
	input wire logic              axis_error,
	input wire logic              origin_refused
);
	localparam int CAP_WAIT = 12;
	logic [1:0] src_reg;
	logic [1:0] src_next;
	logic       a_armed;

	// source kept from each accepted arm
	always_comb begin
		src_next = src_reg;
		if (arm_position_capture && !capture_armed) src_next = arm_arg.source;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) src_reg <= 2'h0;
		else src_reg <= src_next;
	end
	assign a_armed = capture_armed && src_reg == apc_pkg::SRC_LATCH_A;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence pin0_rise_s;
		a_armed && latch_source_selector[3:0] == apc_pkg::SEL_RISE_IN0 && $rose(reg_pin[0]);
	endsequence
	sequence a_off_s;
		(a_armed && latch_source_selector[3:0] == apc_pkg::SEL_FORCE_OFF) [*8];
	endsequence

	arm_takes_a:
	assert property (arm_position_capture && !capture_armed |=> capture_armed && !capture_done)
		else $error("arm not taken");
	pin_capture_a:
	assert property (pin0_rise_s |-> ##[1:CAP_WAIT] capture_done && !capture_armed)
		else $error("capture late");
	done_cause_a:
	assert property ($rose(capture_done) |-> $past(capture_armed))
		else $error("capture without arming");
	single_shot_a:
	assert property (capture_done && !arm_position_capture
		|=> capture_done && $stable(captured_position)) else $error("second capture");
	off_silent_a:
	assert property (a_off_s |-> !capture_done) else $error("forced off fired");
	origin_zero_a:
	assert property (origin_search_command
		|=> demanded_position == $past(measured_position) && !axis_error)
		else $error("origin zero wrong");
	origin_load_a:
	assert property (origin_load |=> measured_position == $past(origin_value))
		else $error("origin load wrong");
	abs_refuse_a:
	assert property (origin_load_abs && !origin_load && !abs_encoder_fitted
		|=> origin_refused ##1 !origin_refused) else $error("refusal wrong");
endmodule : apc_capture_checker

bind apc_capture apc_capture_checker i_chk (.clock, .rst_n, .reg_pin, .latch_source_selector,
	.arm_position_capture, .arm_arg, .capture_armed, .capture_done, .captured_position,
	.origin_search_command, .origin_load, .origin_load_abs, .abs_encoder_fitted,
	.origin_value, .measured_position, .demanded_position, .axis_error, .origin_refused);

// *** sim/apc_enc_model.sv ***
/* encoder model: axis moving one count per clock, sampled every
   SAMPLE_CYC clocks, zero mark once per REV counts. */
`timescale 1ns/10ps
module apc_enc_model #(
	parameter int REV = 16384
) (
	// clock and reset
	input  wire logic   clock,
	input  wire logic   rst_n,
	// encoder outputs
	output logic        enc_sample_valid,
	output logic [31:0] enc_sample,
	output logic        zero_mark_pin,
	output logic [31:0] true_pos
);
	logic tick;
	assign tick = (true_pos % apc_pkg::SAMPLE_CYC) == 0;
	// axis motion and sample stream
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{true_pos, enc_sample_valid, enc_sample, zero_mark_pin} <= '0;
		end else begin
			true_pos <= true_pos + 32'h1;
			enc_sample_valid <= tick;
			// data only meaningful with its strobe
			enc_sample <= tick ? true_pos : ~true_pos;
			zero_mark_pin <= (true_pos % REV) < 4;
		end
	end
endmodule : apc_enc_model

// *** sim/tb_top.sv ***
/* bench for apc_capture: encoder model on the far side, queue of
   expected capture positions, origin load checks. */
`timescale 1ns/10ps
module tb_top;
	localparam int REV = 16384;
	localparam int TOL = 12;
	localparam int CAP_WAIT = 12;
	logic        clock, rst_n, zero_mark_pin, enc_sample_valid, abs_encoder_fitted;
	logic        arm_position_capture, origin_search_command, origin_load, origin_load_abs;
	logic        capture_armed, capture_done, axis_error, origin_refused;
	logic [2:0]  reg_pin;
	logic [11:0] latch_source_selector;
	logic [31:0] enc_sample, true_pos, abs_enc_position, origin_value, demanded_in;
	logic [31:0] captured_position, measured_position, demanded_position, rnd;
	apc_pkg::apc_arg_t arm_arg;
	int          mismatches = 0, checks_done = 0, cycles = 0;
	logic [31:0] exp_q[$];

	apc_capture i_dut (.clock, .rst_n, .reg_pin, .zero_mark_pin, .enc_sample_valid, .enc_sample,
		.abs_enc_position, .abs_encoder_fitted, .latch_source_selector, .arm_position_capture,
		.arm_arg, .origin_search_command, .origin_load, .origin_load_abs, .origin_value,
		.demanded_in, .capture_armed, .capture_done, .captured_position, .measured_position,
		.demanded_position, .axis_error, .origin_refused);
	apc_enc_model #(.REV(REV)) i_enc (.clock, .rst_n, .enc_sample_valid, .enc_sample,
		.zero_mark_pin, .true_pos);

	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			$display("Error timeout expected done seen hang");
			finish_test;
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_pos(input logic [31:0] exp, got);
		logic signed [31:0] d;
		d = got - exp;
		checks_done++;
		if ((d <= TOL && d >= -TOL) !== 1'b1) begin
			mismatches++;
			$display("Error position expected %0d seen %0d", exp, got);
		end
	endtask : chk_pos

	task automatic pulse_arm(input logic [1:0] src, input logic inv);
		@(posedge clock);
		rnd = xs(rnd);
		arm_arg <= '{src, inv, rnd[0]};
		arm_position_capture <= 1'b1;
		@(posedge clock);
		arm_position_capture <= 1'b0;
		#1 chk("armed", 1'b1, capture_armed);
	endtask : pulse_arm

	task automatic wait_done(input int lim);
		int n;
		n = 0;
		#1;
		while (capture_done !== 1'b1 && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("done", 1'b1, capture_done);
		chk("armed", 1'b0, capture_armed);
		chk_pos(exp_q.pop_front(), captured_position);
	endtask : wait_done

	// latch l on pin p: a foreign pin first, then the real edge, then a repeat
	task automatic cap_case(input int l, input int p, input logic [3:0] code);
		logic [11:0] sel;
		logic        fall;
		logic [31:0] e;
		sel = 12'h777;
		sel[4*l +: 4] = code;
		fall = code[3];
		@(posedge clock);
		latch_source_selector <= sel;
		reg_pin <= {3{fall}};
		repeat (6) @(posedge clock);
		pulse_arm(2'(l), 1'b0);
		@(posedge clock);
		reg_pin[(p + 1) % 3] <= ~fall;
		repeat (10) @(posedge clock);
		#1 chk("idle", 1'b0, capture_done);
		@(posedge clock);
		reg_pin[p] <= ~fall;
		e = true_pos;
		exp_q.push_back(e);
		wait_done(CAP_WAIT);
		@(posedge clock);
		reg_pin[p] <= fall;
		repeat (8) @(posedge clock);
		reg_pin[p] <= ~fall;
		repeat (20) @(posedge clock);
		#1 chk_pos(e, captured_position);
	endtask : cap_case

	task automatic origin_op(input int op);
		@(posedge clock);
		origin_search_command <= (op == 0);
		origin_load <= (op == 1);
		origin_load_abs <= (op == 2);
		@(posedge clock);
		{origin_search_command, origin_load, origin_load_abs} <= 3'h0;
		#1;
	endtask : origin_op

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	initial begin
		logic [3:0]  odd[5];
		logic [31:0] av;
		rnd = 32'h1C;
		rst_n = 1'b0;
		reg_pin = 3'h0;
		latch_source_selector = 12'h777;
		arm_arg = '0;
		{arm_position_capture, origin_search_command, origin_load, origin_load_abs} = 4'h0;
		{abs_encoder_fitted, abs_enc_position, origin_value, demanded_in} = '0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge enc_sample_valid);
		for (int i = 0; i < 6; i++) begin
			cap_case(i % 3, (i + 1) % 3, (i < 3 ? 4'h4 : 4'hD) + 4'((i + 1) % 3));
		end
		$display("test edges done");
		rnd = xs(rnd);
		odd = '{4'h7, 4'h8, 4'h0, 4'h3, 4'h9 + 4'(rnd[1:0])};
		foreach (odd[j]) begin
			@(posedge clock);
			reg_pin <= 3'h0;
			latch_source_selector <= {8'h77, odd[j]};
			repeat (4) @(posedge clock);
			pulse_arm(apc_pkg::SRC_LATCH_A, 1'b0);
			for (int t = 0; t < 4; t++) begin
				repeat (4) @(posedge clock);
				reg_pin[0] <= ~reg_pin[0];
			end
			repeat (12) @(posedge clock);
			#1 chk("silent", 1'b0, capture_done);
			@(posedge clock);
			latch_source_selector <= {8'h77, apc_pkg::SEL_RISE_IN0};
			repeat (6) @(posedge clock);
			reg_pin[0] <= 1'b1;
			exp_q.push_back(true_pos);
			wait_done(CAP_WAIT);
		end
		// inverted edge: pin 0 stands high, its fall must capture
		pulse_arm(apc_pkg::SRC_LATCH_A, 1'b1);
		repeat (6) @(posedge clock);
		reg_pin[0] <= 1'b0;
		exp_q.push_back(true_pos);
		wait_done(CAP_WAIT);
		$display("test codes done");
		// arm far from a mark so the next mark is the one expected
		wait ((true_pos % REV) == REV / 2);
		pulse_arm(apc_pkg::SRC_ZERO, 1'b0);
		exp_q.push_back((true_pos / REV + 1) * REV);
		wait_done(REV + 50);
		$display("test zero mark done");
		@(posedge enc_sample_valid);
		repeat (3) @(posedge clock);
		rnd = xs(rnd);
		av = {rnd[15:0], rnd[31:16]};
		origin_value <= rnd;
		demanded_in <= ~rnd;
		abs_enc_position <= av;
		abs_encoder_fitted <= 1'b1;
		origin_op(1);
		chk("measured", rnd, measured_position);
		origin_op(0);
		chk("demanded", rnd, demanded_position);
		chk("error", 1'b0, axis_error);
		origin_op(2);
		chk("measured", av, measured_position);
		chk("demanded", ~rnd, demanded_position);
		@(posedge clock);
		abs_encoder_fitted <= 1'b0;
		origin_op(2);
		chk("refused", 1'b1, origin_refused);
		chk("measured", av, measured_position);
		$display("test origin done");
		finish_test;
	end
endmodule : tb_top
